// *** design/cow_decoder.sv ***
/*
 holds the code option word decoder top: the two configuration words,
 their decode onto oscillator, watchdog, protection and pin controls,
 the serial data input delay and the shared reset or port pin.
 assumes a plain register port with one cycle read latency and one
 system clock; the clock, watchdog and reset blocks are outside.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cow_consts.svh"

//////////////////////////////////////////////////////////////////////////////
module cow_decoder
   import cow_pkg::*;
#(
   parameter int ADDR_W = 4,
   parameter int DATA_W = 16,
   parameter int DLY_DEPTH = `COW_DELAY_100_CYC
)
(
   input wire logic CLK_SYS_I,
   input wire logic RST_B_I,
   input wire logic CE_I,
   input wire logic [ADDR_W-1:0] ADDR_I,
   input wire logic [DATA_W-1:0] WDATA_I,
   input wire logic WR_I,
   input wire logic RD_I,
   output logic [DATA_W-1:0] RDATA_O,
   input wire logic SERIAL_DATA_INPUT_I,
   output logic SERIAL_DATA_DELAYED_O,
   input wire logic PORT7_BIT0_PIN_I,
   output logic PORT7_BIT0_PIN_O,
   output logic PORT7_BIT0_PIN_OE_O,
   input wire logic PORT7_BIT0_CORE_OUT_I,
   input wire logic PORT7_BIT0_CORE_OE_I,
   output logic PORT7_BIT0_CORE_IN_O,
   output logic EXT_RESET_B_O,
   output logic OSC_TYPE_SELECT_O,
   output logic WATCHDOG_ENABLE_O,
   output logic FOUR_CLOCK_CYCLE_O,
   output logic CODE_PROTECT_ON_O,
   output logic CRYSTAL_RANGE_SELECT_O,
   output logic RC_CAPACITOR_SOURCE_O,
   output logic OSCILLATOR_POWER_SELECT_O,
   output logic [4:0] OSC_MODE_O,
   output logic HIGH_CRYSTAL_MODE_O,
   output logic LOW_CRYSTAL_MODE_O,
   output logic EXTERNAL_RC_MODE_O,
   output logic INTERNAL_CAP_MODE_O,
   output logic CONFIG_FAULT_O,
   output logic [`COW_WORD_W-1:0] USER_ID_O
);

   localparam int WW = `COW_WORD_W;
   localparam int DLY_SEL_W = $clog2(DLY_DEPTH + 1);

   if (DATA_W < WW || ADDR_W < 2 || DLY_DEPTH < `COW_DELAY_100_CYC)
   begin : g_chk
      $error("cow_decoder parameters too small for the option words");
   end

   ///////////////////////////////////////////////////////////////////////////
   // decode functions

   // oscillator mode from type, capacitor, range and power bits
   function automatic cow_osc_mode_t osc_mode_f(input logic [WW-1:0] w);
      logic xtal;
      xtal = w[`COW_B_OSC_TYPE];
      return (xtal && w[`COW_B_RANGE]) ? COW_MODE_HIGH_CRYSTAL :
         (xtal && !w[`COW_B_POWER]) ? COW_MODE_LOW_CRYSTAL :
         xtal ? COW_MODE_UNDEFINED :
         w[`COW_B_RC_CAP] ? COW_MODE_EXTERNAL_RC : COW_MODE_INTERNAL_CAP;
   endfunction : osc_mode_f

   // serial input delay in cycles; codes 0 and 3 both give no delay
   function automatic logic [DLY_SEL_W-1:0] dly_cnt_f(
      input logic [WW-1:0] w);
      logic [1:0] c;
      c = {w[`COW_B_DLY_HI], w[`COW_B_DLY_LO]};
      return (c == 2'h1) ? DLY_SEL_W'(`COW_DELAY_50_CYC) :
         (c == 2'h2) ? DLY_SEL_W'(`COW_DELAY_100_CYC) : '0;
   endfunction : dly_cnt_f

   ///////////////////////////////////////////////////////////////////////////
   // option word registers

   logic [WW-1:0] word0_q;
   logic [WW-1:0] word1_q;
   logic [DATA_W-1:0] rdata_q;
   logic sel_word0;
   logic sel_word1;
   logic sel_status;

   // address decode of the register port
   assign sel_word0 = (ADDR_I == ADDR_W'(`COW_ADDR_WORD0));
   assign sel_word1 = (ADDR_I == ADDR_W'(`COW_ADDR_WORD1));
   assign sel_status = (ADDR_I == ADDR_W'(`COW_ADDR_STATUS));

   // word writes; the status word is read only
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         word0_q <= `COW_WORD0_RST;
         word1_q <= `COW_WORD1_RST;
      end
      else if (CE_I && WR_I)
      begin
         if (sel_word0)
         begin
            word0_q <= WDATA_I[WW-1:0];
         end
         if (sel_word1)
         begin
            word1_q <= WDATA_I[WW-1:0];
         end
      end
   end

   ///////////////////////////////////////////////////////////////////////////
   // field decode

   cow_osc_mode_t mode_d;
   logic [DLY_SEL_W-1:0] dly_cnt;
   logic range_fault;
   logic dly_fault;
   logic reset_pin_mode;

   // only the named fields are looked at; bits 2:0 feed only the word 0 read back
   assign mode_d = osc_mode_f(word0_q);
   assign dly_cnt = dly_cnt_f(word0_q);
   assign range_fault = !word0_q[`COW_B_OSC_TYPE] && word0_q[`COW_B_RANGE];
   assign dly_fault = !word0_q[`COW_B_DLY_HI] && !word0_q[`COW_B_DLY_LO];
   assign reset_pin_mode = !word0_q[`COW_B_RST_EN];

   logic osc_type_q;
   logic wdt_en_q;
   logic four_clk_q;
   logic protect_q;
   logic range_q;
   logic rc_cap_q;
   logic power_q;
   cow_osc_mode_t mode_q;
   logic fault_q;
   logic [WW-1:0] user_id_q;

   // decoded controls held in flip-flops
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         osc_type_q <= 1'b0;
         wdt_en_q <= 1'b0;
         four_clk_q <= 1'b0;
         protect_q <= 1'b0;
         range_q <= 1'b0;
         rc_cap_q <= 1'b0;
         power_q <= 1'b0;
         mode_q <= COW_MODE_UNDEFINED;
         fault_q <= 1'b0;
         user_id_q <= '0;
      end
      else if (CE_I)
      begin
         osc_type_q <= word0_q[`COW_B_OSC_TYPE];
         wdt_en_q <= !word0_q[`COW_B_WDT_DIS];
         four_clk_q <= word0_q[`COW_B_CLK_CNT];
         protect_q <= !word0_q[`COW_B_PROTECT];
         range_q <= word0_q[`COW_B_OSC_TYPE] && word0_q[`COW_B_RANGE];
         rc_cap_q <= word0_q[`COW_B_RC_CAP];
         power_q <= word0_q[`COW_B_POWER];
         mode_q <= mode_d;
         fault_q <= range_fault || dly_fault || mode_d == COW_MODE_UNDEFINED;
         user_id_q <= word1_q;
      end
   end

   assign OSC_TYPE_SELECT_O = osc_type_q;
   assign WATCHDOG_ENABLE_O = wdt_en_q;
   assign FOUR_CLOCK_CYCLE_O = four_clk_q;
   assign CODE_PROTECT_ON_O = protect_q;
   assign CRYSTAL_RANGE_SELECT_O = range_q;
   assign RC_CAPACITOR_SOURCE_O = rc_cap_q;
   assign OSCILLATOR_POWER_SELECT_O = power_q;
   assign OSC_MODE_O = mode_q;
   assign HIGH_CRYSTAL_MODE_O = (mode_q == COW_MODE_HIGH_CRYSTAL);
   assign LOW_CRYSTAL_MODE_O = (mode_q == COW_MODE_LOW_CRYSTAL);
   assign EXTERNAL_RC_MODE_O = (mode_q == COW_MODE_EXTERNAL_RC);
   assign INTERNAL_CAP_MODE_O = (mode_q == COW_MODE_INTERNAL_CAP);
   assign CONFIG_FAULT_O = fault_q;
   assign USER_ID_O = user_id_q;

   ///////////////////////////////////////////////////////////////////////////
   // serial data input delay

   logic sdi_sync;

   cow_sync #(
      .RST_VAL (1'b0)
   ) u_sdi_sync (
      .clk_i (CLK_SYS_I),
      .rst_b_i (RST_B_I),
      .ce_i (CE_I),
      .d_i (SERIAL_DATA_INPUT_I),
      .q_o (sdi_sync)
   );

   cow_delay #(
      .DEPTH (DLY_DEPTH),
      .SEL_W (DLY_SEL_W)
   ) u_sdi_delay (
      .clk_i (CLK_SYS_I),
      .rst_b_i (RST_B_I),
      .ce_i (CE_I),
      .din_i (sdi_sync),
      .sel_i (dly_cnt),
      .dout_o (SERIAL_DATA_DELAYED_O)
   );

   ///////////////////////////////////////////////////////////////////////////
   // shared reset or port pin

   logic pin_sync;

   cow_sync #(
      .RST_VAL (1'b1)
   ) u_pin_sync (
      .clk_i (CLK_SYS_I),
      .rst_b_i (RST_B_I),
      .ce_i (CE_I),
      .d_i (PORT7_BIT0_PIN_I),
      .q_o (pin_sync)
   );

   // reset mode never drives the pin and hides it from the port logic
   assign PORT7_BIT0_PIN_O = reset_pin_mode ? 1'b0 : PORT7_BIT0_CORE_OUT_I;
   assign PORT7_BIT0_PIN_OE_O = !reset_pin_mode && PORT7_BIT0_CORE_OE_I;
   assign PORT7_BIT0_CORE_IN_O = reset_pin_mode ? 1'b0 : pin_sync;
   assign EXT_RESET_B_O = reset_pin_mode ? pin_sync : 1'b1;

   ///////////////////////////////////////////////////////////////////////////
   // register read port

   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] rd_mux;

   // status word: live mode, faults, pin levels and delay count
   assign status_word = DATA_W'({dly_cnt, pin_sync, sdi_sync, dly_fault,
      range_fault, 5'(mode_d)});
   assign rd_mux = sel_word0 ? DATA_W'(word0_q) :
      sel_word1 ? DATA_W'(word1_q) :
      sel_status ? status_word : '0;

   // read data stands for the one cycle after the strobe only
   always_ff @(posedge CLK_SYS_I or negedge RST_B_I)
   begin
      if (!RST_B_I)
      begin
         rdata_q <= '0;
      end
      else if (CE_I)
      begin
         rdata_q <= RD_I ? rd_mux : '0;
      end
   end

   assign RDATA_O = rdata_q;

   ///////////////////////////////////////////////////////////////////////////
   // checks

   a_osc_type_write: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      (CE_I && WR_I && sel_word0) ##1 CE_I
      |=> OSC_TYPE_SELECT_O == $past(WDATA_I[`COW_B_OSC_TYPE], 2))
      else $error("oscillator type does not follow word0 write");
   a_wdt_inverted: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      CE_I |=> WATCHDOG_ENABLE_O != $past(word0_q[`COW_B_WDT_DIS]))
      else $error("watchdog enable sense wrong");
   a_clock_count: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      CE_I |=> FOUR_CLOCK_CYCLE_O == $past(word0_q[`COW_B_CLK_CNT]))
      else $error("clocks per cycle select wrong");
   a_protect_sense: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      CE_I |=> CODE_PROTECT_ON_O == !$past(word0_q[`COW_B_PROTECT]))
      else $error("code protection sense wrong");
   a_range_gated: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      CRYSTAL_RANGE_SELECT_O |-> OSC_TYPE_SELECT_O)
      else $error("crystal range active outside crystal type");
   a_cap_power: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      CE_I |=> {RC_CAPACITOR_SOURCE_O, OSCILLATOR_POWER_SELECT_O} ==
      {$past(word0_q[`COW_B_RC_CAP]), $past(word0_q[`COW_B_POWER])})
      else $error("capacitor source or power select wrong");
   a_reset_pin_mode: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      reset_pin_mode |-> !PORT7_BIT0_PIN_OE_O && EXT_RESET_B_O == pin_sync
      && !PORT7_BIT0_CORE_IN_O)
      else $error("shared pin not in reset role");
   a_user_id_load: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      (CE_I && WR_I && sel_word1) ##1 (CE_I && !WR_I)
      |=> USER_ID_O == $past(WDATA_I[WW-1:0], 2))
      else $error("user id does not follow word1 write");
   a_mode_decode: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      (CE_I && word0_q[`COW_B_OSC_TYPE] && word0_q[`COW_B_RANGE])
      |=> HIGH_CRYSTAL_MODE_O && !LOW_CRYSTAL_MODE_O)
      else $error("high crystal mode not decoded");
   // the first edge after reset loads the outputs, so it is left out
   a_low_bits_inert: assert property (
      @(posedge CLK_SYS_I) disable iff (!RST_B_I)
      (CE_I && $past(CE_I) && $past(RST_B_I)
      && $stable(word0_q[WW-1:`COW_B_RST_EN]))
      |=> $stable({OSC_MODE_O, WATCHDOG_ENABLE_O, FOUR_CLOCK_CYCLE_O,
      CODE_PROTECT_ON_O, CRYSTAL_RANGE_SELECT_O, CONFIG_FAULT_O}))
      else $error("unassigned word0 bits changed behaviour");

endmodule : cow_decoder

`default_nettype wire

// *** design/cow_consts.svh ***
/*
 holds the numeric constants of the code option word decoder: register
 offsets, field positions, reset values and input delay timing.
 assumes it is included by its bare name from design files only.
*/
`ifndef COW_CONSTS_SVH
`define COW_CONSTS_SVH

// configuration word width and register offsets
`define COW_WORD_W 13
`define COW_ADDR_WORD0 4'h0
`define COW_ADDR_WORD1 4'h1
`define COW_ADDR_STATUS 4'h2

// word 0 field positions
`define COW_B_OSC_TYPE 12
`define COW_B_WDT_DIS 11
`define COW_B_CLK_CNT 10
`define COW_B_PROTECT 9
`define COW_B_RANGE 8
`define COW_B_RC_CAP 7
`define COW_B_POWER 6
`define COW_B_DLY_HI 5
`define COW_B_DLY_LO 4
`define COW_B_RST_EN 3

// status register field positions
`define COW_S_MODE_LSB 0
`define COW_S_RANGE_FLT 5
`define COW_S_DLY_FLT 6
`define COW_S_SDI_LVL 7
`define COW_S_PIN_LVL 8
`define COW_S_DLY_LSB 9

// reset values of the two words
`define COW_WORD0_RST 13'h1fff
`define COW_WORD1_RST 13'h0000

// input delay timing
`define COW_CLK_MHZ 25
`define COW_CLK_PERIOD_NS (1000 / `COW_CLK_MHZ)
`define COW_DELAY_50_NS 50
`define COW_DELAY_100_NS 100
`define COW_DELAY_50_CYC \
   ((`COW_DELAY_50_NS + `COW_CLK_PERIOD_NS - 1) / `COW_CLK_PERIOD_NS)
`define COW_DELAY_100_CYC \
   ((`COW_DELAY_100_NS + `COW_CLK_PERIOD_NS - 1) / `COW_CLK_PERIOD_NS)

`endif

// *** design/cow_pkg.sv ***
/*
 holds the types of the code option word decoder.
 assumes nothing of its surroundings.
*/
package cow_pkg;

   // decoded oscillator mode, one-hot
   typedef enum logic [4:0]
   {
      COW_MODE_HIGH_CRYSTAL = 5'h01,
      COW_MODE_LOW_CRYSTAL = 5'h02,
      COW_MODE_EXTERNAL_RC = 5'h04,
      COW_MODE_INTERNAL_CAP = 5'h08,
      COW_MODE_UNDEFINED = 5'h10
   } cow_osc_mode_t;

endpackage : cow_pkg

// *** design/cow_sync.sv ***
/*
 holds a three stage pin synchroniser with an output flip-flop that follows only once
 the second and third stages agree.
 assumes a single clock and an asynchronous active low reset.
*/
`timescale 1ns/1ns
`default_nettype none

module cow_sync
#(
   parameter logic RST_VAL = 1'b0
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic d_i,
   output var logic q_o
);

   logic s1_q;
   logic s2_q;
   logic s3_q;
   logic q_q;

   // three stages; the output only moves when stage two and three agree
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         s1_q <= RST_VAL;
         s2_q <= RST_VAL;
         s3_q <= RST_VAL;
         q_q <= RST_VAL;
      end
      else if (ce_i)
      begin
         s1_q <= d_i;
         s2_q <= s1_q;
         s3_q <= s2_q;
         if (s2_q == s3_q)
         begin
            q_q <= s3_q;
         end
      end
   end

   assign q_o = q_q;

endmodule : cow_sync

`default_nettype wire

// *** design/cow_delay.sv ***
/*
 holds a selectable delay line of whole clock cycles; tap zero is the
 input itself.
 assumes the input already comes from a flip-flop on the same clock.
*/
`timescale 1ns/1ns
`default_nettype none

module cow_delay
#(
   parameter int DEPTH = 3,
   parameter int SEL_W = $clog2(DEPTH + 1)
)
(
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic ce_i,
   input wire logic din_i,
   input wire logic [SEL_W-1:0] sel_i,
   output logic dout_o
);

   logic [DEPTH:0] tap;

   if (DEPTH < 1)
   begin : g_chk
      $error("cow_delay needs a depth of at least one");
   end

   assign tap[0] = din_i;

   // one flip-flop per cycle of delay
   for (genvar i = 1; i <= DEPTH; i++)
   begin : g_tap
      logic tap_q;
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
         begin
            tap_q <= 1'b0;
         end
         else if (ce_i)
         begin
            tap_q <= tap[i-1];
         end
      end
      assign tap[i] = tap_q;
   end

   // tap select; out of range indices fall back to no delay
   assign dout_o = (int'(sel_i) <= DEPTH) ? tap[sel_i] : tap[0];

   a_two_cycle_tap: assert property (
      @(posedge clk_i) disable iff (!rst_b_i)
      (DEPTH >= 2 && sel_i == SEL_W'(2) && $past(sel_i) == SEL_W'(2)
       && $past(ce_i) && $past(ce_i, 2))
      |-> dout_o == $past(din_i, 2))
      else $error("two cycle delay tap does not match input");

endmodule : cow_delay

`default_nettype wire

// *** testbench/tb_cow_decoder.sv ***
/*
 self-checking bench for the code option word decoder: table of word 0
 values, reset values, user id, ignored accesses, back to back access,
 serial input delay, shared pin and a second reset.
 assumes the design files are compiled first and a 25 MHz clock.
*/
`timescale 1ns/1ns
`default_nettype none
`define TB_CHK(g, e) cmp(16'(g), 16'(e))

module tb_cow_decoder
   import cow_pkg::*;
;
   typedef struct {logic [12:0] w; logic [4:0] m; logic f;} cow_tb_row_t;

   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic ce = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [15:0] wdata = 16'h0000;
   logic wr_strb = 1'b0;
   logic rd_strb = 1'b0;
   logic serial_data_input = 1'b0;
   logic pin_in = 1'b1;
   logic core_out = 1'b0;
   logic core_oe = 1'b0;
   logic [15:0] rdata;
   logic sdi_dly, pin_o, pin_oe, core_in, ext_rst_b, osc_type, wdt_en;
   logic four_clk, prot_on, range, rc_cap, power, high_crystal_mode, low_crystal_mode, external_rc_mode, icap;
   logic fault;
   logic [4:0] mode;
   logic [12:0] user_id;
   logic [15:0] d;
   int n_mismatch = 0;
   int checked = 0;
   int lat [3];
   int dly_exp [3] = '{0, 2, 3};
   logic [1:0] codes [3] = '{2'b11, 2'b01, 2'b10};
   // word 0 values, the mode and fault that each must give
   cow_tb_row_t rows [8] = '{
      '{13'h1fff, COW_MODE_HIGH_CRYSTAL, 1'b0},
      '{13'h1030, COW_MODE_LOW_CRYSTAL, 1'b0},
      '{13'h1070, COW_MODE_UNDEFINED, 1'b1},
      '{13'h00b8, COW_MODE_EXTERNAL_RC, 1'b0},
      '{13'h0038, COW_MODE_INTERNAL_CAP, 1'b0},
      '{13'h0138, COW_MODE_INTERNAL_CAP, 1'b1},
      '{13'h1fc7, COW_MODE_HIGH_CRYSTAL, 1'b1},
      '{13'h1ff8, COW_MODE_HIGH_CRYSTAL, 1'b0}};

   cow_decoder #(.ADDR_W(4), .DATA_W(16)) u_dut (
      .CLK_SYS_I(clk_sys), .RST_B_I(rst_b), .CE_I(ce), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr_strb), .RD_I(rd_strb), .RDATA_O(rdata),
      .SERIAL_DATA_INPUT_I(serial_data_input), .SERIAL_DATA_DELAYED_O(sdi_dly),
      .PORT7_BIT0_PIN_I(pin_in), .PORT7_BIT0_PIN_O(pin_o),
      .PORT7_BIT0_PIN_OE_O(pin_oe), .PORT7_BIT0_CORE_OUT_I(core_out),
      .PORT7_BIT0_CORE_OE_I(core_oe), .PORT7_BIT0_CORE_IN_O(core_in),
      .EXT_RESET_B_O(ext_rst_b), .OSC_TYPE_SELECT_O(osc_type),
      .WATCHDOG_ENABLE_O(wdt_en), .FOUR_CLOCK_CYCLE_O(four_clk),
      .CODE_PROTECT_ON_O(prot_on), .CRYSTAL_RANGE_SELECT_O(range),
      .RC_CAPACITOR_SOURCE_O(rc_cap), .OSCILLATOR_POWER_SELECT_O(power),
      .OSC_MODE_O(mode), .HIGH_CRYSTAL_MODE_O(high_crystal_mode),
      .LOW_CRYSTAL_MODE_O(low_crystal_mode), .EXTERNAL_RC_MODE_O(external_rc_mode),
      .INTERNAL_CAP_MODE_O(icap), .CONFIG_FAULT_O(fault),
      .USER_ID_O(user_id));

   // 40 ns period
   always #20 clk_sys = ~clk_sys;

   //////////////////////////////////////////////////////////////////////////
   // helpers
   task cmp(input logic [15:0] g, input logic [15:0] e);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("ERROR at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp

   task final_report;
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : final_report

   task end_test(input string name);
      $display("test %s finished", name);
   endtask : end_test

   // reset held for 3 cycles; returns at the first edge after release
   task do_reset;
      rst_b <= 1'b0;
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
   endtask : do_reset

   // one cycle write, then one idle cycle so strobes never merge
   task bus_wr(input logic [3:0] a, input logic [15:0] v);
      addr <= a;
      wdata <= v;
      wr_strb <= 1'b1;
      @(posedge clk_sys);
      wr_strb <= 1'b0;
      @(posedge clk_sys);
   endtask : bus_wr

   // read data are taken in the cycle after the strobe
   task bus_rd(input logic [3:0] a, output logic [15:0] v);
      addr <= a;
      rd_strb <= 1'b1;
      @(posedge clk_sys);
      rd_strb <= 1'b0;
      @(negedge clk_sys);
      v = rdata;
      @(posedge clk_sys);
   endtask : bus_rd

   // decoded outputs against the bits of the word
   task chk_dec(input logic [12:0] w, input logic [4:0] m, input logic f);
      `TB_CHK({osc_type, wdt_en}, {w[12], ~w[11]});
      `TB_CHK({four_clk, prot_on}, {w[10], ~w[9]});
      `TB_CHK(range, w[8] & w[12]);
      `TB_CHK({rc_cap, power}, {w[7], w[6]});
      `TB_CHK(mode, m);
      `TB_CHK({high_crystal_mode, low_crystal_mode, external_rc_mode, icap}, {m[0], m[1], m[2], m[3]});
      `TB_CHK(fault, f);
   endtask : chk_dec

   //////////////////////////////////////////////////////////////////////////
   // main sequence
   initial
   begin
      do_reset;
      @(negedge clk_sys);
      chk_dec(13'h1fff, COW_MODE_HIGH_CRYSTAL, 1'b0);
      `TB_CHK({user_id, ext_rst_b}, 14'h0001);
      @(posedge clk_sys);
      bus_rd(4'h0, d);
      `TB_CHK(d, 16'h1fff);
      bus_rd(4'h1, d);
      `TB_CHK(d, 16'h0000);
      end_test("reset");

      foreach (rows[i])
      begin
         bus_wr(4'h0, {3'b000, rows[i].w});
         @(negedge clk_sys);
         chk_dec(rows[i].w, rows[i].m, rows[i].f);
         @(posedge clk_sys);
         bus_rd(4'h0, d);
         `TB_CHK(d, {3'b000, rows[i].w});
         bus_rd(4'h2, d);
         `TB_CHK(d[4:0], rows[i].m);
      end
      end_test("table");

      // id word is stored whole and leaves the decode alone
      bus_wr(4'h1, 16'hffff);
      @(negedge clk_sys);
      `TB_CHK(user_id, 13'h1fff);
      chk_dec(13'h1ff8, COW_MODE_HIGH_CRYSTAL, 1'b0);
      @(posedge clk_sys);
      bus_rd(4'h1, d);
      `TB_CHK(d, 16'h1fff);
      bus_wr(4'h1, 16'h0a5c);
      @(negedge clk_sys);
      `TB_CHK(user_id, 13'h0a5c);
      @(posedge clk_sys);
      end_test("user id");

      // status, unmapped and clock-disabled writes change nothing
      bus_wr(4'h2, 16'h0000);
      bus_wr(4'h7, 16'h0000);
      ce <= 1'b0;
      bus_wr(4'h0, 16'h0000);
      ce <= 1'b1;
      bus_rd(4'h0, d);
      `TB_CHK(d, 16'h1ff8);
      bus_rd(4'h5, d);
      `TB_CHK(d, 16'h0000);
      end_test("ignored");

      // write then read with no gap; read data stand one cycle
      addr <= 4'h0;
      wdata <= 16'h1030;
      wr_strb <= 1'b1;
      @(posedge clk_sys);
      wr_strb <= 1'b0;
      rd_strb <= 1'b1;
      @(posedge clk_sys);
      rd_strb <= 1'b0;
      @(negedge clk_sys);
      `TB_CHK(rdata, 16'h1030);
      @(negedge clk_sys);
      `TB_CHK(rdata, 16'h0000);
      chk_dec(13'h1030, COW_MODE_LOW_CRYSTAL, 1'b0);
      @(posedge clk_sys);
      end_test("back to back");

      // edges from a serial input change to the delayed output
      for (int k = 0; k < 3; k++)
      begin
         bus_wr(4'h0, 16'h1fcf | (16'(codes[k]) << 4));
         bus_rd(4'h2, d);
         `TB_CHK(d[10:9], dly_exp[k]);
         repeat (8) @(posedge clk_sys);
         serial_data_input <= ~serial_data_input;
         lat[k] = 0;
         // let the new input level settle before comparing against it
         @(negedge clk_sys);
         while (lat[k] < 20 && sdi_dly !== serial_data_input)
         begin
            @(negedge clk_sys);
            lat[k]++;
         end
         @(posedge clk_sys);
      end
      // 50 ns and 100 ns at a 40 ns period round up to 2 and 3 cycles
      `TB_CHK(lat[1] - lat[0], 2);
      `TB_CHK(lat[2] - lat[0], 3);
      `TB_CHK(lat[0] < 8, 1'b1);
      end_test("input delay");

      // pin as port: core drives it; as reset: pin goes to reset only
      bus_wr(4'h0, 16'h1fff);
      core_oe <= 1'b1;
      core_out <= 1'b1;
      pin_in <= 1'b0;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      `TB_CHK({pin_oe, pin_o, ext_rst_b, core_in}, 4'b1110);
      @(posedge clk_sys);
      bus_wr(4'h0, 16'h1ff7);
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      `TB_CHK({pin_oe, ext_rst_b, core_in}, 3'b000);
      @(posedge clk_sys);
      pin_in <= 1'b1;
      repeat (8) @(posedge clk_sys);
      @(negedge clk_sys);
      `TB_CHK({ext_rst_b, core_in}, 2'b10);
      @(posedge clk_sys);
      end_test("shared pin");

      // a reset in mid-run restores both words
      bus_wr(4'h1, 16'h0123);
      do_reset;
      @(negedge clk_sys);
      `TB_CHK(user_id, 13'h0000);
      chk_dec(13'h1fff, COW_MODE_HIGH_CRYSTAL, 1'b0);
      @(posedge clk_sys);
      bus_rd(4'h0, d);
      `TB_CHK(d, 16'h1fff);
      end_test("second reset");
      final_report;
   end

   // the sequence needs some 185 cycles; this cuts a hang short
   initial
   begin
      repeat (5000) @(posedge clk_sys);
      n_mismatch++;
      final_report;
   end

endmodule : tb_cow_decoder

`default_nettype wire
